// ==== src/adcsp_top.sv ====
// Serial port, register file and result-ready logic of the converter
`timescale 1ns/1ps
`include "adcsp_regs.svh"
module adcsp_top (
	input  wire logic        mclk,
	input  wire logic        rst_n,
	input  wire logic        sclk,
	input  wire logic        cs_n,
	input  wire logic        sdi,
	output logic             sdo,
	output logic             sdo_oe,
	output logic             rdy_n,
	input  wire logic        standby_n,
	input  wire logic        conv_valid,
	input  wire logic [23:0] conv_data,
	input  wire logic        cal_done,
	output logic             cal_start,
	output logic             core_run
);
	// ****************************************
	// Link domain: serial shifting
	// ****************************************
	logic        sb_s1_r;
	logic        sb_s2_r;
	logic        lk_cmd_r;
	logic        lk_cmd_nxt;
	logic [5:0]  lk_cnt_r;
	logic [5:0]  lk_cnt_nxt;
	logic [23:0] lk_in_r;
	logic [23:0] lk_in_nxt;
	logic [23:0] lk_out_r;
	logic [23:0] lk_out_nxt;
	logic [2:0]  lk_sel_r;
	logic [2:0]  lk_sel_nxt;
	logic        lk_rd_r;
	logic        lk_rd_nxt;
	logic        lk_push;
	logic        fifo_rdy;
	adcsp_pkg::adcsp_xfer_t lk_word;
	logic        rdtog_r;
	logic        rdtog_nxt;
	logic [23:0] snap [8];

	// Live register values, read across domains when the command byte ends, with no stability check
	logic [23:0] comm_r;
	logic [23:0] stat_w;
	logic [23:0] data_r;
	logic [23:0] mode_r;
	logic [23:0] filt_r;
	logic [23:0] dac_r;
	logic [23:0] offs_r;
	logic [23:0] gain_r;

	always_comb begin
		snap[`ADCSP_SEL_COMM] = comm_r;
		snap[`ADCSP_SEL_STAT] = stat_w;
		snap[`ADCSP_SEL_DATA] = data_r;
		snap[`ADCSP_SEL_MODE] = mode_r;
		snap[`ADCSP_SEL_FILT] = filt_r;
		snap[`ADCSP_SEL_DAC]  = dac_r;
		snap[`ADCSP_SEL_OFFS] = offs_r;
		snap[`ADCSP_SEL_GAIN] = gain_r;
	end

	always_comb begin
		lk_cmd_nxt = lk_cmd_r;
		lk_cnt_nxt = lk_cnt_r;
		lk_in_nxt  = {lk_in_r[22:0], sdi};
		lk_out_nxt = {lk_out_r[22:0], 1'b0};
		lk_sel_nxt = lk_sel_r;
		lk_rd_nxt  = lk_rd_r;
		rdtog_nxt  = rdtog_r;
		lk_push    = 1'b0;
		lk_word    = '0;
		if (lk_cmd_r && lk_cnt_r == `ADCSP_CMD_BITS - 6'h01) begin
			lk_sel_nxt = lk_in_nxt[`ADCSP_COMM_SEL_LSB +: 3];
			lk_rd_nxt  = lk_in_nxt[`ADCSP_COMM_RD_BIT];
			lk_cnt_nxt = 6'h00;
			lk_cmd_nxt = 1'b0;
			lk_push    = !lk_in_nxt[`ADCSP_COMM_RD_BIT];
			lk_word.sel  = `ADCSP_SEL_COMM;
			lk_word.rd   = lk_in_nxt[`ADCSP_COMM_RD_BIT];
			lk_word.data = {16'h0000, lk_in_nxt[7:0]};
			lk_out_nxt = snap[lk_in_nxt[`ADCSP_COMM_SEL_LSB +: 3]];
		end else if (!lk_cmd_r && lk_cnt_r == `ADCSP_WORD_BITS - 6'h01) begin
			lk_cnt_nxt = 6'h00;
			lk_cmd_nxt = 1'b1;
			lk_push    = !lk_rd_r;
			lk_word.sel  = lk_sel_r;
			lk_word.rd   = lk_rd_r;
			lk_word.data = lk_in_nxt;
			if (lk_rd_r && lk_sel_r == `ADCSP_SEL_DATA) begin
				rdtog_nxt = !rdtog_r;
			end
		end else begin
			lk_cnt_nxt = lk_cnt_r + 6'h01;
		end
	end

	// Standby pin passes two flops before the core reads it
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			sb_s1_r  <= 1'b1;
			sb_s2_r  <= 1'b1;
		end else begin
			sb_s1_r  <= standby_n;
			sb_s2_r  <= sb_s1_r;
		end
	end

	// Chip select high resets the frame asynchronously, so framing works with a stopped clock
	always_ff @(posedge sclk or negedge rst_n or posedge cs_n) begin
		if (!rst_n || cs_n) begin
			lk_cmd_r <= 1'b1;
			lk_cnt_r <= 6'h00;
			lk_in_r  <= 24'h000000;
			lk_out_r <= 24'h000000;
			lk_sel_r <= 3'h0;
			lk_rd_r  <= 1'b0;
		end else begin
			lk_cmd_r <= lk_cmd_nxt;
			lk_cnt_r <= lk_cnt_nxt;
			lk_in_r  <= lk_in_nxt;
			lk_out_r <= lk_out_nxt;
			lk_sel_r <= lk_sel_nxt;
			lk_rd_r  <= lk_rd_nxt;
		end
	end

	always_ff @(posedge sclk or negedge rst_n) begin
		if (!rst_n) begin
			rdtog_r <= 1'b0;
		end else begin
			rdtog_r <= (cs_n) ? rdtog_r : rdtog_nxt;
		end
	end

	assign sdo    = lk_out_r[23];
	assign sdo_oe = !cs_n && lk_rd_r && !lk_cmd_r;

	// ****************************************
	// Crossing: FIFO of written words, toggle for reads
	// ****************************************
	// Words are handed across through a link-side holding register and a req/ack handshake
	logic [27:0] hs_data_r;
	logic        hs_req_r;
	logic        ack_s1_r;
	logic        ack_s2_r;
	logic        req_s1_r;
	logic        req_s2_r;
	logic        req_s3_r;
	logic        ack_r;
	logic        cvalid;
	logic        cready;
	logic [27:0] cdata;
	adcsp_pkg::adcsp_xfer_t cw;

	assign fifo_rdy = hs_req_r == ack_s2_r;

	always_ff @(posedge sclk or negedge rst_n) begin
		if (!rst_n) begin
			hs_data_r <= 28'h0000000;
			hs_req_r  <= 1'b0;
			ack_s1_r  <= 1'b0;
			ack_s2_r  <= 1'b0;
		end else begin
			ack_s1_r <= ack_r;
			ack_s2_r <= ack_s1_r;
			if (lk_push && fifo_rdy && !cs_n) begin
				hs_data_r <= lk_word;
				hs_req_r  <= !hs_req_r;
			end
		end
	end

	logic rd_s1_r;
	logic rd_s2_r;
	logic rd_s3_r;
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			req_s1_r <= 1'b0;
			req_s2_r <= 1'b0;
			req_s3_r <= 1'b0;
			ack_r    <= 1'b0;
			rd_s1_r  <= 1'b0;
			rd_s2_r  <= 1'b0;
			rd_s3_r  <= 1'b0;
		end else begin
			req_s1_r <= hs_req_r;
			req_s2_r <= req_s1_r;
			req_s3_r <= req_s2_r;
			ack_r    <= req_s2_r;
			rd_s1_r  <= rdtog_r;
			rd_s2_r  <= rd_s1_r;
			rd_s3_r  <= rd_s2_r;
		end
	end

	adcsp_fifo #(.WIDTH(28), .DEPTH(4)) u_fifo (
		.mclk      (mclk),
		.rst_n     (rst_n),
		.in_valid  (req_s2_r != req_s3_r),
		.in_ready  (),
		.in_data   (hs_data_r),
		.out_valid (cvalid),
		.out_ready (cready),
		.out_data  (cdata)
	);

	// ****************************************
	// Core domain: registers and result-ready
	// ****************************************
	adcsp_pkg::adcsp_rdy_st_t st_r;
	adcsp_pkg::adcsp_rdy_st_t st_nxt;
	logic [7:0]  upd_r;
	logic [7:0]  upd_nxt;
	logic        cal_r;
	logic        cal_nxt;
	logic        cal_start_nxt;
	logic [23:0] comm_nxt;
	logic [23:0] data_nxt;
	logic [23:0] mode_nxt;
	logic [23:0] filt_nxt;
	logic [23:0] dac_nxt;
	logic [23:0] offs_nxt;
	logic [23:0] gain_nxt;
	logic        rd_done;

	assign cw       = cdata;
	assign cready   = sb_s2_r;
	assign rd_done  = rd_s2_r != rd_s3_r;
	assign stat_w   = {rdy_n, cal_r, st_r, 20'h00000};
	assign core_run = sb_s2_r;

	always_comb begin
		comm_nxt = comm_r;
		data_nxt = data_r;
		mode_nxt = mode_r;
		filt_nxt = filt_r;
		dac_nxt  = dac_r;
		offs_nxt = offs_r;
		gain_nxt = gain_r;
		st_nxt   = st_r;
		upd_nxt  = upd_r;
		cal_nxt  = cal_r;
		cal_start_nxt = 1'b0;
		if (sb_s2_r) begin
			if (cvalid) begin
				case (cw.sel)
					`ADCSP_SEL_COMM: comm_nxt = cw.data;
					`ADCSP_SEL_MODE: begin
						mode_nxt = cw.data;
						if (cw.data[`ADCSP_MODE_CAL_BIT]) begin
							cal_nxt       = 1'b1;
							cal_start_nxt = 1'b1;
						end
					end
					`ADCSP_SEL_FILT: filt_nxt = cw.data;
					`ADCSP_SEL_DAC:  dac_nxt  = cw.data;
					`ADCSP_SEL_OFFS: offs_nxt = cw.data;
					`ADCSP_SEL_GAIN: gain_nxt = cw.data;
					default: ;
				endcase
			end
			if (cal_r && cal_done && !cal_start_nxt) begin
				cal_nxt = 1'b0;
				st_nxt  = adcsp_pkg::ADCSP_READY;
			end
			case (st_r)
				adcsp_pkg::ADCSP_IDLE: begin
					if (conv_valid && !cal_r) begin
						st_nxt  = adcsp_pkg::ADCSP_BUSY;
						upd_nxt = `ADCSP_UPD_CYC;
					end
				end
				adcsp_pkg::ADCSP_BUSY: begin
					upd_nxt = upd_r - 8'h01;
					if (upd_r == 8'h01) begin
						st_nxt   = adcsp_pkg::ADCSP_READY;
						data_nxt = conv_data;
					end
				end
				adcsp_pkg::ADCSP_READY: begin
					if (rd_done) begin
						st_nxt = adcsp_pkg::ADCSP_IDLE;
					end else if (conv_valid && !cal_r) begin
						st_nxt  = adcsp_pkg::ADCSP_BUSY;
						upd_nxt = `ADCSP_UPD_CYC;
					end
				end
				default: st_nxt = adcsp_pkg::ADCSP_IDLE;
			endcase
			if (cal_nxt) begin
				st_nxt = adcsp_pkg::ADCSP_IDLE;
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			comm_r    <= 24'h000000;
			data_r    <= 24'h000000;
			mode_r    <= `ADCSP_MODE_RST;
			filt_r    <= `ADCSP_FILT_RST;
			dac_r     <= `ADCSP_DAC_RST;
			offs_r    <= `ADCSP_OFFS_RST;
			gain_r    <= `ADCSP_GAIN_RST;
			st_r      <= adcsp_pkg::ADCSP_IDLE;
			upd_r     <= 8'h00;
			cal_r     <= 1'b0;
			cal_start <= 1'b0;
			rdy_n     <= 1'b1;
		end else begin
			comm_r    <= comm_nxt;
			data_r    <= data_nxt;
			mode_r    <= mode_nxt;
			filt_r    <= filt_nxt;
			dac_r     <= dac_nxt;
			offs_r    <= offs_nxt;
			gain_r    <= gain_nxt;
			st_r      <= st_nxt;
			upd_r     <= upd_nxt;
			cal_r     <= cal_nxt;
			cal_start <= cal_start_nxt;
			rdy_n     <= st_nxt != adcsp_pkg::ADCSP_READY;
		end
	end
endmodule

// ==== src/adcsp_regs.svh ====
// Constants for the converter serial port block
`ifndef ADCSP_REGS_SVH
`define ADCSP_REGS_SVH
// Register selection codes carried in the communications word
`define ADCSP_SEL_COMM   3'h0
`define ADCSP_SEL_STAT   3'h1
`define ADCSP_SEL_DATA   3'h2
`define ADCSP_SEL_MODE   3'h3
`define ADCSP_SEL_FILT   3'h4
`define ADCSP_SEL_DAC    3'h5
`define ADCSP_SEL_OFFS   3'h6
`define ADCSP_SEL_GAIN   3'h7
// Communications word fields
`define ADCSP_COMM_RD_BIT  6
`define ADCSP_COMM_SEL_LSB 0
// Reset values
`define ADCSP_MODE_RST   24'h000000
`define ADCSP_FILT_RST   24'h200000
`define ADCSP_DAC_RST    24'h000000
`define ADCSP_OFFS_RST   24'h800000
`define ADCSP_GAIN_RST   24'h599999
// Mode register field: high bit set selects calibration
`define ADCSP_MODE_CAL_BIT 23
// Cycles the output register is considered busy around an update
`define ADCSP_UPD_CYC    8'h04
// Frame lengths in bits
`define ADCSP_CMD_BITS   6'h08
`define ADCSP_WORD_BITS  6'h18
`endif

// ==== src/adcsp_pkg.sv ====
// Types shared by the converter serial port block
package adcsp_pkg;
	typedef struct packed {
		logic [2:0]  sel;
		logic        rd;
		logic [23:0] data;
	} adcsp_xfer_t;
	typedef enum logic [1:0] {
		ADCSP_IDLE,
		ADCSP_BUSY,
		ADCSP_READY
	} adcsp_rdy_st_t;
endpackage

// ==== src/adcsp_fifo.sv ====
// Small FIFO carrying finished input words into the core domain
`timescale 1ns/1ps
module adcsp_fifo #(
	parameter int WIDTH = 28,
	parameter int DEPTH = 4
) (
	input  wire logic             mclk,
	input  wire logic             rst_n,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW:0]      wp_r;
	logic [AW:0]      wp_nxt;
	logic [AW:0]      rp_r;
	logic [AW:0]      rp_nxt;
	logic             push;
	logic             pop;

	assign in_ready  = (wp_r - rp_r) != (AW+1)'(DEPTH);
	assign out_valid = wp_r != rp_r;
	assign out_data  = mem_r[rp_r[AW-1:0]];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	always_comb begin
		wp_nxt = wp_r + (AW+1)'(push);
		rp_nxt = rp_r + (AW+1)'(pop);
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			wp_r <= '0;
			rp_r <= '0;
		end else begin
			wp_r <= wp_nxt;
			rp_r <= rp_nxt;
		end
	end

	always_ff @(posedge mclk) begin
		if (push) begin
			mem_r[wp_r[AW-1:0]] <= in_data;
		end
	end
endmodule

// ==== verif/adcsp_top_sva.sv ====
// Concurrent checks on the converter serial port pins
`timescale 1ns/1ps
module adcsp_top_sva (
	input wire logic        mclk,
	input wire logic        rst_n,
	input wire logic        sclk,
	input wire logic        cs_n,
	input wire logic        sdi,
	input wire logic        sdo,
	input wire logic        sdo_oe,
	input wire logic        rdy_n,
	input wire logic        standby_n,
	input wire logic        conv_valid,
	input wire logic [23:0] conv_data,
	input wire logic        cal_done,
	input wire logic        cal_start,
	input wire logic        core_run
);
	logic [5:0] cnt_r, cnt_nxt;
	logic [7:0] cmd_r, cmd_nxt;
	logic       cal_r, cal_nxt;
	// Bit count and command byte of the frame, calibration in flight
	always_comb begin
		cnt_nxt = cnt_r + 6'h01;
		cmd_nxt = (cnt_r < 6'h08) ? {cmd_r[6:0], sdi} : cmd_r;
		cal_nxt = cal_start | (cal_r & ~cal_done);
	end
	always_ff @(posedge sclk or negedge rst_n or posedge cs_n) begin
		if (!rst_n || cs_n) begin
			cnt_r <= 6'h00;
			cmd_r <= 8'h00;
		end else begin
			cnt_r <= cnt_nxt;
			cmd_r <= cmd_nxt;
		end
	end
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			cal_r <= 1'b0;
		else
			cal_r <= cal_nxt;
	end
	a_run_tracks_hold: assert property (@(posedge mclk) disable iff (!rst_n) core_run == $past(standby_n, 2))
		else $error("core_run wrong");
	a_idle_no_drive: assert property (@(posedge mclk) disable iff (!rst_n) cs_n |-> !sdo_oe)
		else $error("sdo driven idle");
	a_oe_after_cmd: assert property (@(posedge sclk) disable iff (!rst_n || cs_n)
		sdo_oe |-> cnt_r >= 6'h08) else $error("sdo early");
	a_oe_read_only: assert property (@(posedge sclk) disable iff (!rst_n || cs_n)
		cnt_r inside {[6'h09:6'h1f]} |-> sdo_oe == cmd_r[6]) else $error("sdo_oe wrong");
	a_cal_pulse: assert property (@(posedge mclk) disable iff (!rst_n) cal_start |=> !cal_start)
		else $error("cal_start long");
	a_cal_holds_rdy: assert property (@(posedge mclk) disable iff (!rst_n) cal_r && $past(cal_r) |-> rdy_n)
		else $error("rdy_n low in cal");
	a_cal_end_rdy: assert property (@(posedge mclk) disable iff (!rst_n) cal_r && cal_done |-> ##[1:6] !rdy_n)
		else $error("rdy_n not low");
	a_update_busy: assert property (@(posedge mclk) disable iff (!rst_n)
		$rose(conv_valid) && core_run && !cal_r |-> ##2 rdy_n [*2] ##[1:6] !rdy_n) else $error("update rdy_n");
	c_cal: cover property (@(posedge mclk) cal_start);
	c_ready: cover property (@(posedge mclk) $fell(rdy_n));
	c_read: cover property (@(posedge sclk) sdo_oe);
endmodule
bind adcsp_top adcsp_top_sva u_sva (.mclk(mclk), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo),
	.sdo_oe(sdo_oe), .rdy_n(rdy_n), .standby_n(standby_n), .conv_valid(conv_valid), .conv_data(conv_data),
	.cal_done(cal_done), .cal_start(cal_start), .core_run(core_run));

// ==== verif/adcsp_host.sv ====
// Host model that frames transfers on the serial port
`timescale 1ns/1ps
module adcsp_host (
	output logic      sclk,
	output logic      cs_n,
	output logic      sdi,
	input  wire logic sdo
);
	initial begin
		sclk = 1'b1;
		cs_n = 1'b1;
		sdi = 1'b0;
	end
	// Clock runs only inside a frame; nb below 32 aborts the word
	task automatic xfer(input logic [7:0] cmd, input logic [23:0] wd, input int nb, output logic [23:0] rd);
		#3 cs_n = 1'b0;
		#8;
		shift(cmd, wd, nb, rd);
		cs_n = 1'b1;
		sdi = ~sdi;
	endtask
	// Three-wire use keeps chip select low and frames by counting clocks alone
	task automatic tie_sel(input logic lvl);
		cs_n = lvl;
	endtask
	task automatic shift(input logic [7:0] cmd, input logic [23:0] wd, input int nb, output logic [23:0] rd);
		logic [31:0] sh;
		sh = {cmd, wd};
		rd = 24'h000000;
		for (int i = 0; i < nb; i++) begin
			sclk = 1'b0;
			if (i >= 8)
				rd = {rd[22:0], sdo};
			sdi = sh[31 - i];
			#16 sclk = 1'b1;
			#16;
		end
	endtask
endmodule

// ==== verif/tb.sv ====
// Self-checking bench for the converter serial port
`timescale 1ns/1ps
`include "adcsp_regs.svh"
module tb;
	typedef struct packed {logic [2:0] sel; logic wr; logic [23:0] d; logic [23:0] exp;} adcsp_row_t;
	logic        mclk, rst_n, sclk, cs_n, sdi, sdo, sdo_oe, rdy_n, standby_n;
	logic        conv_valid, cal_done, cal_start, core_run;
	logic        cal_seen = 1'b0;
	logic [23:0] conv_data, rd;
	int          error_cnt, num_checks;
	adcsp_row_t  rows [10] = '{
		'{3'h3, 1'b0, 24'h000000, `ADCSP_MODE_RST}, '{3'h4, 1'b0, 24'h000000, `ADCSP_FILT_RST},
		'{3'h5, 1'b0, 24'h000000, `ADCSP_DAC_RST}, '{3'h6, 1'b0, 24'h000000, `ADCSP_OFFS_RST},
		'{3'h7, 1'b0, 24'h000000, `ADCSP_GAIN_RST}, '{3'h3, 1'b1, 24'h0a5a5a, 24'h0a5a5a},
		'{3'h4, 1'b1, 24'h123456, 24'h123456}, '{3'h5, 1'b1, 24'h00003f, 24'h00003f},
		'{3'h6, 1'b1, 24'hfedcba, 24'hfedcba}, '{3'h7, 1'b1, 24'h5a5a5a, 24'h5a5a5a}};
	adcsp_top DUT (.mclk(mclk), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe),
		.rdy_n(rdy_n), .standby_n(standby_n), .conv_valid(conv_valid), .conv_data(conv_data), .cal_done(cal_done),
		.cal_start(cal_start), .core_run(core_run));
	adcsp_host h (.sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo));
	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end
	always @(posedge mclk) if (cal_start === 1'b1) cal_seen <= 1'b1;
	initial begin
		#300000;
		error_cnt++;
		complete_run;
	end
	task automatic chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
		num_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic complete_run;
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic wr_reg(input logic [2:0] sel, input logic [23:0] d);
		h.xfer({5'h00, sel}, d, 32, rd);
		repeat (12) @(negedge mclk);
	endtask
	task automatic rd_reg(input logic [2:0] sel);
		h.xfer({5'h08, sel}, 24'h000000, 32, rd);
		repeat (12) @(negedge mclk);
	endtask
	task automatic wait_rdy(input logic lvl);
		for (int i = 0; i < 80 && rdy_n !== lvl; i++)
			@(negedge mclk);
	endtask
	task automatic pulse(input logic [23:0] d);
		conv_data = d;
		conv_valid = 1'b1;
		@(negedge mclk);
		conv_valid = 1'b0;
		@(negedge mclk);
	endtask
	initial begin
		{rst_n, standby_n, conv_valid, cal_done} = 4'h4;
		conv_data = 24'h000000;
		error_cnt = 0;
		num_checks = 0;
		repeat (6) @(negedge mclk);
		chk("rdy_n", 24'(rdy_n), 24'h000001);
		rst_n = 1'b1;
		repeat (4) @(negedge mclk);
		foreach (rows[i]) begin
			if (rows[i].wr)
				wr_reg(rows[i].sel, rows[i].d);
			rd_reg(rows[i].sel);
			chk("reg", rd, rows[i].exp);
		end
		pulse(24'habcdef);
		wait_rdy(1'b0);
		chk("rdy_n", 24'(rdy_n), 24'h000000);
		rd_reg(3'h2);
		chk("data", rd, 24'habcdef);
		chk("rdy_n", 24'(rdy_n), 24'h000001);
		pulse(24'h135790);
		wait_rdy(1'b0);
		pulse(24'h2468ac);
		chk("rdy_n", 24'(rdy_n), 24'h000001);
		wait_rdy(1'b0);
		wr_reg(3'h2, 24'h000111);
		rd_reg(3'h2);
		chk("data", rd, 24'h2468ac);
		h.xfer({5'h00, 3'h7}, 24'h000000, 20, rd);
		rd_reg(3'h7);
		chk("gain", rd, 24'h5a5a5a);
		pulse(24'h0f0f0f);
		wait_rdy(1'b0);
		chk("rdy_n", 24'(rdy_n), 24'h000000);
		wr_reg(3'h3, 24'h800000);
		chk("cal_start", 24'(cal_seen), 24'h000001);
		chk("rdy_n", 24'(rdy_n), 24'h000001);
		cal_done = 1'b1;
		@(negedge mclk);
		cal_done = 1'b0;
		wait_rdy(1'b0);
		chk("rdy_n", 24'(rdy_n), 24'h000000);
		standby_n = 1'b0;
		repeat (8) @(negedge mclk);
		chk("core_run", 24'(core_run), 24'h000000);
		pulse(24'h777777);
		chk("rdy_n", 24'(rdy_n), 24'h000000);
		rd_reg(3'h2);
		chk("data", rd, 24'h0f0f0f);
		standby_n = 1'b1;
		rd_reg(3'h4);
		chk("filter", rd, 24'h123456);
		h.tie_sel(1'b0);
		repeat (4) @(negedge mclk);
		h.shift({5'h00, 3'h5}, 24'h00002a, 32, rd);
		repeat (12) @(negedge mclk);
		h.shift({5'h08, 3'h5}, 24'h000000, 32, rd);
		chk("dac", rd, 24'h00002a);
		h.tie_sel(1'b1);
		repeat (2) @(negedge mclk);
		rst_n = 1'b0;
		repeat (2) @(negedge mclk);
		chk("rdy_n", 24'(rdy_n), 24'h000001);
		rst_n = 1'b1;
		repeat (4) @(negedge mclk);
		rd_reg(3'h4);
		chk("filter", rd, `ADCSP_FILT_RST);
		complete_run;
	end
endmodule
